// File: rtl/audio_out_pkg.sv
package audio_out_pkg;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_LEFT_JUST = 2'h1,
    FMT_PULSE = 2'h2
  } frame_fmt_t;

  typedef enum logic [1:0] {
    LEN_8 = 2'h0,
    LEN_16 = 2'h1,
    LEN_20 = 2'h2,
    LEN_24 = 2'h3
  } word_len_t;

  typedef enum logic [1:0] {
    OUT_ANALOG = 2'h0,
    OUT_DIGITAL = 2'h1,
    OUT_BOTH = 2'h2
  } out_mode_t;

  localparam int SAMPLE_W = 24;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] BITS_8 = 6'h08;
  localparam logic [CNT_W-1:0] BITS_16 = 6'h10;
  localparam logic [CNT_W-1:0] BITS_20 = 6'h14;
  localparam logic [CNT_W-1:0] BITS_24 = 6'h18;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [1:0] DELAY_NONE = 2'h0;
  localparam logic [1:0] DELAY_ONE = 2'h1;
endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // sync reset, active low
  input wire logic pin, // asynchronous input
  output logic level, // filtered level
  output logic rise, // one-cycle pulse on rise
  output logic fall // one-cycle pulse on fall
);
  logic s1;
  logic s2;
  logic s3;
  wire agree = (s2 == s3);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        level <= s3;
      end
    end
  end

  // edges only once stages two and three agree
  assign rise = agree && s3 && !level;
  assign fall = agree && !s3 && level;
endmodule

// File: rtl/radio_digital_audio_out.sv
`timescale 1ns/100ps
module radio_digital_audio_out
  import audio_out_pkg::*;
(
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rstn, // sync reset, active low
  input wire logic serial_bit_clock, // bit clock from master
  input wire logic frame_sync, // frame sync from master
  input wire logic [1:0] frameFormat, // frame_fmt_t
  input wire logic [1:0] wordLength, // word_len_t
  input wire logic [1:0] outputMode, // out_mode_t
  input wire logic fallingCapture, // master captures on falling edge
  input wire logic pulseLateMsb, // pulse format: msb on second edge
  input wire logic [SAMPLE_W-1:0] leftSample, // left sample, msb aligned
  input wire logic [SAMPLE_W-1:0] rightSample, // right sample, msb aligned
  input wire logic [SAMPLE_W-1:0] analogLeftIn, // left code to dac
  input wire logic [SAMPLE_W-1:0] analogRightIn, // right code to dac
  output logic serialData, // serial data out
  output logic serialDataOe, // data pin driven
  output logic [SAMPLE_W-1:0] analog_left_out, // left dac code
  output logic [SAMPLE_W-1:0] analog_right_out, // right dac code
  output logic analogEnable, // analog path active
  output logic sampleTaken // pulse when a stereo pair is latched
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SHIFT = 3'b100
  } shift_st_t;

  logic bclkLevel;
  logic bclkRise;
  logic bclkFall;
  logic fsLevel;
  logic fsRise;
  logic fsFall;

  pin_sync u_bclk (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(serial_bit_clock),
    .level(bclkLevel),
    .rise(bclkRise),
    .fall(bclkFall)
  );

  pin_sync u_fs (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(frame_sync),
    .level(fsLevel),
    .rise(fsRise),
    .fall(fsFall)
  );

  shift_st_t state;
  shift_st_t next_state;
  logic [SAMPLE_W-1:0] shiftReg;
  logic [SAMPLE_W-1:0] rightHold;
  logic [CNT_W-1:0] bitsLeft;
  logic [1:0] delayLeft;
  logic fsPrev;
  logic rightPending;

  wire digitalOn = (outputMode == OUT_DIGITAL) || (outputMode == OUT_BOTH);
  wire analogOn = (outputMode == OUT_ANALOG) || (outputMode == OUT_BOTH);
  // capture edge is where the master samples; launch on the opposite edge
  wire launchEdge = fallingCapture ? bclkRise : bclkFall;
  wire isPulse = (frameFormat == FMT_PULSE);
  // sync level with an edge found this cycle folded in
  wire fsNow = (fsLevel || fsRise) && !fsFall;
  // sync moves on the launch edge; starting there lets a zero-delay msb meet the next capture
  wire fsChange = launchEdge && (fsNow != fsPrev);
  wire pulseStart = isPulse && launchEdge && fsNow && !fsPrev;
  wire i2sStart = !isPulse && fsChange;
  wire wordStart = (pulseStart || i2sStart) && digitalOn;
  // channel chosen by level in the two level formats
  wire leftPhase = (frameFormat == FMT_I2S) ? !fsNow : fsNow;
  wire [SAMPLE_W-1:0] startWord = (isPulse || leftPhase) ? leftSample : rightSample;
  // first edge after sync: msb launched before next capture; second: one extra
  wire [1:0] startDelay = (frameFormat == FMT_I2S) ? DELAY_ONE :
                          (isPulse && pulseLateMsb) ? DELAY_ONE : DELAY_NONE;
  shift_st_t startState;
  assign startState = (startDelay == DELAY_NONE) ? ST_SHIFT : ST_WAIT;
  wire [CNT_W-1:0] wordBits = (wordLength == LEN_8) ? BITS_8 :
                              (wordLength == LEN_16) ? BITS_16 :
                              (wordLength == LEN_20) ? BITS_20 : BITS_24;
  wire lastBit = (bitsLeft == CNT_ONE);
  wire chainRight = isPulse && rightPending;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (wordStart) begin
          next_state = startState;
        end
      end
      ST_WAIT: begin
        if (wordStart) begin
          next_state = startState;
        end else if (launchEdge && delayLeft <= DELAY_ONE) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (wordStart) begin
          next_state = startState;
        end else if (launchEdge && lastBit && !chainRight) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      fsPrev <= 1'b0;
    end else begin
      state <= next_state;
      if (launchEdge) begin
        fsPrev <= fsNow;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shiftReg <= '0;
      rightHold <= '0;
      bitsLeft <= CNT_ZERO;
      delayLeft <= DELAY_NONE;
      rightPending <= 1'b0;
      sampleTaken <= 1'b0;
    end else begin
      sampleTaken <= wordStart && (isPulse || leftPhase);
      if (wordStart) begin
        shiftReg <= startWord;
        rightHold <= rightSample;
        rightPending <= isPulse;
        bitsLeft <= wordBits;
        delayLeft <= startDelay;
      end else if (state == ST_WAIT && launchEdge) begin
        if (delayLeft != DELAY_NONE) begin
          delayLeft <= delayLeft - DELAY_ONE;
        end
      end else if (state == ST_SHIFT && launchEdge) begin
        if (lastBit && chainRight) begin
          shiftReg <= rightHold;
          bitsLeft <= wordBits;
          rightPending <= 1'b0;
        end else begin
          shiftReg <= {shiftReg[SAMPLE_W-2:0], 1'b0};
          bitsLeft <= bitsLeft - CNT_ONE;
        end
      end
    end
  end

  // output register: msb of shifter while shifting, else low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      serialData <= 1'b0;
      serialDataOe <= 1'b0;
      analog_left_out <= '0;
      analog_right_out <= '0;
      analogEnable <= 1'b0;
    end else begin
      serialDataOe <= digitalOn;
      analogEnable <= analogOn;
      if (analogOn) begin
        analog_left_out <= analogLeftIn;
        analog_right_out <= analogRightIn;
      end
      if (!digitalOn || next_state != ST_SHIFT) begin
        serialData <= 1'b0;
      end else if (wordStart) begin
        serialData <= startWord[SAMPLE_W-1];
      end else if (state == ST_SHIFT && launchEdge && lastBit && chainRight) begin
        serialData <= rightHold[SAMPLE_W-1];
      end else if (state == ST_SHIFT && launchEdge) begin
        serialData <= shiftReg[SAMPLE_W-2];
      end else begin
        serialData <= shiftReg[SAMPLE_W-1];
      end
    end
  end

  a_idle_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    (next_state != ST_SHIFT) |=> !serialData)
    else $error("data not low while idle");
  a_msb_now: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wordStart && startDelay == DELAY_NONE) |=>
      (state == ST_SHIFT && serialData == $past(startWord[SAMPLE_W-1])))
    else $error("msb not launched with the sync edge");
  a_mode_oe: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 serialDataOe == $past(digitalOn))
    else $error("output enable does not follow mode");
  a_analog_en: assert property (@(posedge sys_clk) disable iff (!rstn)
    (outputMode == OUT_BOTH) |=> (analogEnable && serialDataOe))
    else $error("both mode not driving all pins");
  a_word_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    wordStart |=> (bitsLeft == $past(wordBits)))
    else $error("word length not loaded");
  a_shift_down: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state == ST_SHIFT && launchEdge && !lastBit && !wordStart) |=>
      (bitsLeft == $past(bitsLeft) - CNT_ONE))
    else $error("bit counter did not step");
  a_i2s_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wordStart && frameFormat == FMT_I2S) |=> (delayLeft == DELAY_ONE))
    else $error("i2s msb delay wrong");
  a_lj_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wordStart && frameFormat == FMT_LEFT_JUST) |=> (delayLeft == DELAY_NONE))
    else $error("left-justified msb delay wrong");
  a_pulse_chain: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state == ST_SHIFT && launchEdge && lastBit && chainRight && !wordStart) |=>
      (state == ST_SHIFT && bitsLeft == $past(wordBits) && !rightPending))
    else $error("right word did not follow left");
  a_no_digital: assert property (@(posedge sys_clk) disable iff (!rstn)
    (outputMode == OUT_ANALOG) |=> !serialData)
    else $error("data toggling in analog mode");
endmodule

// File: verif/audio_master.sv
`timescale 1ns/100ps
module audio_master
  import audio_out_pkg::*;
(
  output logic serial_bit_clock, // bit clock, still between bursts
  output logic frame_sync, // frame sync
  input wire logic serialData // data from device
);
  logic [23:0] capLeft;
  logic [23:0] capRight;
  logic [7:0] idleHigh;
  // 125 bit clocks of 200 ns make a 40 kHz frame
  localparam int FRAME_BITS = 125;
  localparam int HALF_BITS = 62;
  initial begin
    serial_bit_clock = 1'b0;
    frame_sync = 1'b0;
  end
  // preset periods flush any stray word left from the last config
  task automatic frames(input logic [1:0] fmt, input logic late, input logic fall, input int len, input int n);
    int d;
    int rs;
    int p;
    d = (fmt == FMT_I2S || (fmt == FMT_PULSE && late)) ? 1 : 0;
    rs = (fmt == FMT_PULSE) ? d + len : HALF_BITS + d;
    capLeft = 24'h000000;
    capRight = 24'h000000;
    idleHigh = 8'h00;
    #7;
    for (int i = -30; i < FRAME_BITS * n; i++) begin
      p = (i < 0) ? FRAME_BITS - 1 : i % FRAME_BITS;
      // each frame's words start from a clean capture
      if (p == 0) begin
        capLeft = 24'h000000;
        capRight = 24'h000000;
      end
      serial_bit_clock = fall;
      frame_sync = (fmt == FMT_PULSE) ? (p == 0) : ((p < HALF_BITS) ^ (fmt == FMT_I2S));
      #100;
      serial_bit_clock = !fall;
      if (i >= 0 && p >= d && p < d + len) capLeft = {capLeft[22:0], serialData};
      else if (i >= 0 && p >= rs && p < rs + len) capRight = {capRight[22:0], serialData};
      else if (i >= 0 && serialData !== 1'b0) idleHigh = idleHigh + 8'h01;
      #100;
    end
    serial_bit_clock = fall;
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import audio_out_pkg::*;
  logic sys_clk, rstn, serial_bit_clock, frame_sync, fallingCapture, pulseLateMsb;
  logic [1:0] frameFormat, wordLength, outputMode;
  logic [23:0] leftSample, rightSample, analogLeftIn, analogRightIn, analog_left_out, analog_right_out;
  logic serialData, serialDataOe, analogEnable, sampleTaken;
  int fail_count, total_checks;
  int takenCount;
  always @(posedge sys_clk) begin
    if (sampleTaken === 1'b1) takenCount++;
  end
  radio_digital_audio_out u_dut (.sys_clk(sys_clk), .rstn(rstn), .serial_bit_clock(serial_bit_clock),
    .frame_sync(frame_sync), .frameFormat(frameFormat), .wordLength(wordLength), .outputMode(outputMode),
    .fallingCapture(fallingCapture), .pulseLateMsb(pulseLateMsb), .leftSample(leftSample),
    .rightSample(rightSample), .analogLeftIn(analogLeftIn), .analogRightIn(analogRightIn),
    .serialData(serialData), .serialDataOe(serialDataOe), .analog_left_out(analog_left_out),
    .analog_right_out(analog_right_out), .analogEnable(analogEnable), .sampleTaken(sampleTaken));
  audio_master u_master (.serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync), .serialData(serialData));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic mode(input logic [1:0] m);
    @(posedge sys_clk);
    outputMode <= m;
    analogLeftIn <= 24'($urandom);
    analogRightIn <= 24'($urandom);
    repeat (6) @(posedge sys_clk);
    #1;
    check(24'(serialDataOe), 24'(m == OUT_DIGITAL || m == OUT_BOTH));
    check(24'(analogEnable), 24'(m == OUT_ANALOG || m == OUT_BOTH));
    if (m == OUT_ANALOG || m == OUT_BOTH) check(analog_left_out, analogLeftIn);
    if (m == OUT_ANALOG || m == OUT_BOTH) check(analog_right_out, analogRightIn);
  endtask
  task automatic run(input logic [1:0] fmt, input logic [1:0] wl, input logic fall, input logic late);
    int len;
    len = (wl == LEN_8) ? 8 : (wl == LEN_16) ? 16 : (wl == LEN_20) ? 20 : 24;
    @(posedge sys_clk);
    frameFormat <= fmt;
    wordLength <= wl;
    fallingCapture <= fall;
    pulseLateMsb <= late;
    // corners: set msb with ones below the word, and a lone lsb
    leftSample <= (wl == LEN_8) ? 24'h80FFFF : 24'($urandom);
    rightSample <= (wl == LEN_24) ? 24'h000001 : 24'($urandom);
    outputMode <= ($urandom % 2 != 0) ? OUT_BOTH : OUT_DIGITAL;
    repeat (8) @(posedge sys_clk);
    takenCount = 0;
    u_master.frames(fmt, late, fall, len, 2);
    check(24'(takenCount), 24'h000002);
    check(u_master.capLeft, leftSample >> (24 - len));
    check(u_master.capRight, rightSample >> (24 - len));
    check({16'h0000, u_master.idleHigh}, 24'h000000);
  endtask
  initial begin
    rstn = 1'b0;
    {fallingCapture, pulseLateMsb, frameFormat, wordLength, outputMode} = 8'h00;
    {leftSample, rightSample, analogLeftIn, analogRightIn} = 96'h0;
    void'($urandom(32'h5448));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(24'({serialData, serialDataOe, analogEnable, sampleTaken}), 24'h000002);
    for (int m = 0; m < 4; m++) mode(2'(m));
    for (int f = 0; f < 3; f++) begin
      for (int w = 0; w < 4; w++) begin
        for (int c = 0; c < 4; c++) begin
          if (c < 2 || f == FMT_PULSE) run(2'(f), 2'(w), c[0], c[1]);
        end
      end
    end
    final_report;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    final_report;
  end
endmodule
